// *** core/precision_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
module precision_timer
    import timer_pkg::*;
(
    // AHB-Lite slave
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Trigger from first timer instance
    input  wire logic        first_timer_instance,
    // Timer pin
    input  wire logic        pin_in,
    output logic             pin_out,
    output logic             pin_oe_n
);
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [6:0]  ctrl;
    logic [6:0]  repc;
    logic [3:0]  list_len;
    logic [14:0] duration_entry [list_depth];
    logic        err;
    run_t        run;
    logic        level;
    logic [14:0] cnt;
    logic [2:0]  idx;
    logic [6:0]  remain;
    logic        phase;
    logic [9:0]  pre_us;
    logic [9:0]  pre_ms;
    logic        tick;
    logic [2:0]  pin_sync;
    logic [2:0]  trig_sync;
    logic        pin_state;
    logic [31:0] capture_time;
    logic [31:0] free_time;

    mode_t mode;
    assign mode = mode_t'(ctrl[mode_lsb +: 3]);

    // Byte address of list entry
    function automatic logic is_list(input logic [7:0] a);
        return a[7:5] == list_base_off[7:5];
    endfunction

    // Command pulses decoded from write data phase
    logic do_cmd, c_start, c_stop, c_reset, c_low, c_high, c_errclr, inv_wr;
    assign do_cmd   = wr_pend && wr_addr == cmd_off;
    assign c_start  = do_cmd && hwdata[cmd_start];
    assign c_stop   = do_cmd && hwdata[cmd_stop];
    assign c_reset  = do_cmd && hwdata[cmd_reset];
    assign c_low    = do_cmd && hwdata[cmd_low];
    assign c_high   = do_cmd && hwdata[cmd_high];
    assign c_errclr = do_cmd && hwdata[cmd_errclr];
    assign inv_wr   = wr_pend && wr_addr == ctrl_off && hwdata[invert_bit] != ctrl[invert_bit];

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= hsel && hready && htrans[1] && hwrite;
            wr_addr <= haddr;
        end
    end

    // Read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            if (haddr == ctrl_off) begin
                hrdata <= {25'h0, ctrl};
            end else if (haddr == repc_off) begin
                hrdata <= {25'h0, repc};
            end else if (haddr == list_len_off) begin
                hrdata <= {28'h0, list_len};
            end else if (haddr == state_off) begin
                hrdata <= {30'h0, run};                             // R6
            end else if (haddr == div_off) begin
                hrdata <= {16'h0, ctrl[unit_bit] ? div_ms_code : div_us_code}; // R6
            end else if (haddr == remain_off) begin
                hrdata <= {25'h0, remain};                          // R7
            end else if (haddr == capture_off) begin
                hrdata <= capture_time;
            end else if (haddr == err_off) begin
                hrdata <= {31'h0, err};
            end else if (is_list(haddr)) begin
                hrdata <= {17'h0, duration_entry[haddr[4:2]]};
            end else begin
                hrdata <= 32'h0;
            end
        end
    end

    // Software configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl     <= 7'h00;                                      // R3 R4 R19 R21
            repc     <= 7'h00;                                      // R11
            list_len <= 4'h0;
        end else if (wr_pend) begin
            if (wr_addr == ctrl_off) begin
                ctrl <= hwdata[6:0];                                // R1 R2 R3 R4
            end else if (wr_addr == repc_off) begin
                repc <= (hwdata[6:0] > repc_max) ? repc_max : hwdata[6:0]; // R11
            end else if (wr_addr == list_len_off) begin
                list_len <= (hwdata[3:0] > 4'h8) ? 4'h8 : hwdata[3:0]; // R12
            end
        end
    end

    // Duration list storage, clamped to 1..32764
    genvar g;
    generate
        for (g = 0; g < list_depth; g++) begin : g_list
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    duration_entry[g] <= 15'h0001;
                end else if (wr_pend && is_list(wr_addr) && wr_addr[4:2] == 3'(g)) begin
                    duration_entry[g] <= (hwdata[14:0] == 15'h0) ? 15'h0001 :
                                         (hwdata[14:0] > dur_max) ? dur_max : hwdata[14:0]; // R12
                end
            end
        end
    endgenerate

    // Prescaler: microsecond and millisecond ticks
    logic us_tick;
    assign us_tick = pre_us == 10'(us_cycles - 1);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_us <= 10'h0;
            pre_ms <= 10'h0;
        end else if (run != st_running) begin
            // Held while stopped or armed so the first duration is whole
            pre_us <= 10'h0;                                        // R22
            pre_ms <= 10'h0;
        end else begin
            pre_us <= us_tick ? 10'h0 : pre_us + 10'h1;
            if (us_tick) begin
                pre_ms <= (pre_ms == 10'(ms_per_us - 1)) ? 10'h0 : pre_ms + 10'h1;
            end
        end
    end
    assign tick = us_tick && (!ctrl[unit_bit] || pre_ms == 10'(ms_per_us - 1)); // R3 R22

    // Synchronisers for pin and trigger
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_sync  <= 3'h0;
            trig_sync <= 3'h0;
            pin_state <= 1'b0;
        end else begin
            pin_sync  <= {pin_sync[1:0], pin_in};
            trig_sync <= {trig_sync[1:0], first_timer_instance};
            if (pin_sync[2] == pin_sync[1]) begin
                pin_state <= pin_sync[2];
            end
        end
    end
    logic trig_lvl;
    assign trig_lvl = (trig_sync[2] == trig_sync[1]) && trig_sync[2];
    logic new_pin, edge_hit;
    assign new_pin  = (pin_sync[2] == pin_sync[1]) ? pin_sync[2] : pin_state;
    assign edge_hit = (mode == mode_rise && !pin_state && new_pin) ||  // R2
                      (mode == mode_fall && pin_state && !new_pin) ||
                      (mode == mode_both && pin_state != new_pin);

    // Free-running time stamp for capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            free_time <= 32'h0;
        end else begin
            free_time <= free_time + 32'h1;
        end
    end

    // Run control, timing, pin level
    logic is_output, expire, last_event;
    assign is_output  = mode == mode_pulse || mode == mode_toggle || mode == mode_pwm;
    assign expire     = run == st_running && is_output && tick && cnt == 15'h1;
    assign last_event = remain == 7'h1 && mode != mode_pwm;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run          <= st_stopped;
            level        <= 1'b0;                                   // R15
            cnt          <= 15'h0;
            idx          <= 3'h0;
            remain       <= 7'h0;
            phase        <= 1'b0;
            err          <= 1'b0;
            capture_time <= 32'h0;
        end else begin
            if (c_errclr) begin
                err <= 1'b0;
            end
            if (c_reset) begin
                run    <= st_stopped;                               // R5
                level  <= 1'b0;                                     // R5 R15
                cnt    <= 15'h0;
                idx    <= 3'h0;
                remain <= 7'h0;
                phase  <= 1'b0;
            end else if (c_stop) begin
                run <= st_stopped;                                  // R8
            end else if (c_low || c_high) begin
                level <= c_high && !c_low;                          // R16
            end else if (c_start && run == st_stopped) begin
                if (list_len == 4'h0) begin
                    err <= 1'b1;                                    // R13
                end else begin
                    run    <= (ctrl[trig_bit] && is_output) ? st_armed : st_running; // R4
                    idx    <= 3'h0;
                    cnt    <= duration_entry[0];
                    remain <= (repc == 7'h0) ? repc_max : repc;     // R11
                    phase  <= 1'b0;
                    if (mode == mode_pulse) begin
                        level <= 1'b0;
                    end
                end
            end else if (run == st_armed) begin
                if (trig_lvl) begin
                    run <= st_running;                              // R4
                end
            end else if (run == st_running && !is_output) begin
                if (edge_hit) begin
                    capture_time <= free_time;
                    remain       <= remain - 7'h1;
                    if (remain == 7'h1) begin
                        run <= st_stopped;
                    end
                end
            end else if (run == st_running && tick) begin
                if (!expire) begin
                    cnt <= cnt - 15'h1;                             // R22
                end else begin
                    level <= !level;                                // R9 R10
                    if (mode == mode_toggle) begin
                        idx <= (4'(idx) + 4'h1 >= list_len) ? 3'h0 : idx + 3'h1; // R14
                        cnt <= duration_entry[(4'(idx) + 4'h1 >= list_len) ? 3'h0 : idx + 3'h1]; // R9 R14
                        remain <= remain - 7'h1;                    // R23
                        if (last_event) begin
                            run <= st_stopped;                      // R23
                        end
                    end else begin
                        phase <= !phase;
                        cnt   <= duration_entry[{2'b00, !phase}];
                        if (phase) begin
                            remain <= (mode == mode_pwm) ? remain : remain - 7'h1;
                            if (last_event) begin
                                run <= st_stopped;                  // R18
                            end
                        end
                    end
                end
            end
        end
    end

    // Inversion toggles the pin level on any change; open-drain releases high
    logic drive;
    assign drive = level ^ ctrl[invert_bit];                        // R17 R20
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out  <= 1'b0;
            pin_oe_n <= 1'b0;
        end else begin
            pin_out  <= (inv_wr ? !drive : drive);                  // R20
            pin_oe_n <= ctrl[od_bit] && (inv_wr ? !drive : drive);  // R19
        end
    end
endmodule
`default_nettype wire

// *** pkg/timer_pkg.sv ***
// Contract
// [R1] Four modes: output pulse, output toggle, output pwm, and pin capture.
// [R2] Capture mode selects rising, falling, or both pin edges.
// [R3] Time unit is microseconds or milliseconds; microseconds by default.
// [R4] Output modes may start on a trigger from the first timer instance; default none.
// [R5] Reset command halts, clears counting state, and drives the pin low; with inversion on, the design drives it high.
// [R6] State reads 0 stopped, 1 to 3 running; unit reads 42 or 42000.
// [R7] Remaining event or capture count is readable, 0 to 64.
// [R8] Stop halts at once; output modes keep the present pin level.
// [R9] Toggle mode inverts the pin when each duration expires, then times the next.
// [R10] First toggle acts on the pin level present at start.
// [R11] Repeat count 0 to 64, default 0, and 0 means 64.
// [R12] Toggle list holds one to eight durations of 1 to 32764 units.
// [R13] Starting without programmed durations raises an error.
// [R14] Toggles beyond the list length wrap to the first duration.
// [R15] Pin low after reboot and reset, otherwise keeps the last level; with inversion on, the reset command drives it high.
// [R16] Forced-level commands set the pin at once without timing.
// [R17] With inversion on, forced levels come out inverted.
// [R18] PWM mode runs an endless pulse train until stop or reset.
// [R19] Pin is push-pull unless open-drain is selected.
// [R20] Changing the inversion setting toggles the pin at once.
// [R21] Inversion is off after reset.
// [R22] A prescaler makes unit ticks; durations decrement once per tick.
// [R23] Remaining count decrements per toggle; at zero the timer stops, keeping the pin.
package timer_pkg;
    // Register byte offsets
    localparam logic [7:0] ctrl_off      = 8'h00;
    localparam logic [7:0] cmd_off       = 8'h04;
    localparam logic [7:0] repc_off      = 8'h08;
    localparam logic [7:0] list_len_off  = 8'h0c;
    localparam logic [7:0] state_off     = 8'h10;
    localparam logic [7:0] div_off       = 8'h14;
    localparam logic [7:0] remain_off    = 8'h18;
    localparam logic [7:0] capture_off   = 8'h1c;
    localparam logic [7:0] err_off       = 8'h20;
    localparam logic [7:0] list_base_off = 8'h40;
    // Control fields
    localparam int mode_lsb   = 0;
    localparam int unit_bit   = 3;
    localparam int trig_bit   = 4;
    localparam int od_bit     = 5;
    localparam int invert_bit = 6;
    // Command bits (write one to act)
    localparam int cmd_start = 0;
    localparam int cmd_stop  = 1;
    localparam int cmd_reset = 2;
    localparam int cmd_low   = 3;
    localparam int cmd_high  = 4;
    localparam int cmd_errclr = 5;
    // Modes
    typedef enum logic [2:0] {
        mode_pulse  = 3'b000,
        mode_toggle = 3'b001,
        mode_pwm    = 3'b010,
        mode_rise   = 3'b011,
        mode_fall   = 3'b100,
        mode_both   = 3'b101
    } mode_t;
    typedef enum logic [1:0] {
        st_stopped = 2'b00,
        st_armed   = 2'b01,
        st_running = 2'b10
    } run_t;
    // Timing
    localparam int clk_mhz     = 125;
    localparam int us_ns       = 1000;
    localparam int clk_ns      = 8;
    localparam int us_cycles   = us_ns / clk_ns;
    localparam int ms_per_us   = 1000;
    localparam logic [15:0] div_us_code = 16'h002a;
    localparam logic [15:0] div_ms_code = 16'ha410;
    localparam logic [14:0] dur_max     = 15'h7ffc;
    localparam logic [6:0]  repc_max    = 7'h40;
    localparam int list_depth  = 8;
endpackage

// *** dv/precision_timer_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module precision_timer_checker
    import timer_pkg::*;
(
    // Bus side
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Trigger and pin
    input wire logic        first_timer_instance,
    input wire logic        pin_in,
    input wire logic        pin_out,
    input wire logic        pin_oe_n
);
    logic       dwr;
    logic       drd;
    logic [7:0] dadr;
    logic       inv;
    logic       od;
    logic       ms;
    logic       cw;
    logic       kw;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Data phase of the transfer taken one edge earlier
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dwr <= 1'b0;
            drd <= 1'b0;
            dadr <= 8'h00;
        end else begin
            dwr <= hsel && hready && htrans[1] && hwrite;
            drd <= hsel && hready && htrans[1] && !hwrite;
            dadr <= haddr;
        end
    end
    assign cw = dwr && dadr == cmd_off;
    assign kw = dwr && dadr == ctrl_off;
    // Shadow of the invert, open-drain and unit control bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            inv <= 1'b0;
            od <= 1'b0;
            ms <= 1'b0;
        end else if (kw) begin
            inv <= hwdata[invert_bit];
            od <= hwdata[od_bit];
            ms <= hwdata[unit_bit];
        end
    end
    a_boot_pin_low: assert property ($rose(hresetn) |-> !pin_out)
        else $error("pin not low after reset");
    a_reset_cmd_low: assert property (cw && hwdata[cmd_reset] && !inv |-> ##2 !pin_out)
        else $error("reset command left pin high");
    a_force_high_lvl: assert property (cw && hwdata[cmd_high] && !hwdata[cmd_low] && hwdata[2:1] == 2'b00
        |-> ##2 pin_out == !inv) else $error("forced high level wrong");
    a_force_low_lvl: assert property (cw && hwdata[cmd_low] && !hwdata[cmd_high] && hwdata[2:1] == 2'b00
        |-> ##2 pin_out == inv) else $error("forced low level wrong");
    a_invert_flips_pin: assert property (kw && hwdata[invert_bit] != inv |-> ##2 pin_out != $past(pin_out, 2))
        else $error("inversion change did not flip pin");
    a_stop_holds_pin: assert property (cw && hwdata[cmd_stop] |-> ##2 $stable(pin_out) [*4])
        else $error("pin moved after stop");
    a_push_pull_drive: assert property ((!od) [*3] |-> !pin_oe_n)
        else $error("push-pull pin not driven");
    a_open_drain_rel: assert property ((od && $stable(pin_out)) [*3] |-> pin_oe_n == pin_out)
        else $error("open-drain enable wrong");
    a_div_read_val: assert property (drd && dadr == div_off |-> hrdata == (ms ? 32'(div_ms_code) : 32'(div_us_code)))
        else $error("unit readback wrong");
    c_forced: cover property (cw && hwdata[cmd_high]);
    c_released: cover property (od && pin_oe_n);
    c_ms_read: cover property (drd && dadr == div_off && ms);
endmodule
bind precision_timer precision_timer_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .first_timer_instance(first_timer_instance), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n));
`default_nettype wire

// *** dv/pin_load.sv ***
`timescale 1ns/10ps
`default_nettype none
module pin_load (
    // Design side
    input  wire logic pin_out,
    input  wire logic pin_oe_n,
    // External source
    input  wire logic src_en,
    input  wire logic src_level,
    // Resolved line
    output logic      pin_in
);
    // Pull-up holds a released line high; an active source wins
    assign pin_in = src_en ? src_level : (pin_oe_n ? 1'b1 : pin_out);
endmodule
`default_nettype wire

// *** dv/precision_timer_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module precision_timer_tb
    import timer_pkg::*;
();
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        trig = 1'b0;
    logic        src_en = 1'b0;
    logic        src_level = 1'b0;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pin_in;
    logic        pin_out;
    logic        pin_oe_n;
    logic [31:0] v;
    logic        lv;
    int          n_tests = 0;
    int          bad_count = 0;
    int          cyc = 0;
    int          dt;
    int          da;
    int          durs[3] = '{1, 2, 1};
    assign hready = hreadyout;
    always #4 hclk = ~hclk;
    always @(posedge hclk) cyc <= cyc + 1;
    precision_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .first_timer_instance(trig), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    pin_load load (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .src_en(src_en), .src_level(src_level), .pin_in(pin_in));
    // Single word transfer; read data taken at the data-phase edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        `CHK(q, e)
    endtask
    task automatic cmd(input int b);
        wr(cmd_off, 32'h1 << b);
    endtask
    task automatic pchk(input logic e);
        repeat (3) @(negedge hclk);
        `CHK(pin_out, e)
    endtask
    // Cycles until the pin next changes, bounded
    task automatic wt(output int n);
        int s;
        logic l;
        s = cyc;
        l = pin_out;
        while (pin_out === l && cyc - s < 20000) @(negedge hclk);
        n = cyc - s;
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog
    initial begin
        #(8 * 40000);
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        pchk(1'b0);
        rchk(state_off, 32'h0);
        rchk(div_off, 32'(div_us_code));
        rchk(repc_off, 32'h0);
        rchk(ctrl_off, 32'h0);
        rchk(8'h30, 32'h0);
        `CHK(pin_oe_n, 1'b0)
        // Forced levels with and without inversion
        cmd(cmd_high);
        pchk(1'b1);
        wr(ctrl_off, 32'h1 << invert_bit);
        pchk(1'b0);
        cmd(cmd_high);
        pchk(1'b0);
        cmd(cmd_low);
        pchk(1'b1);
        wr(ctrl_off, 32'h0);
        pchk(1'b0);
        // Open drain releases a high level to the pull-up
        wr(ctrl_off, 32'h1 << od_bit);
        cmd(cmd_high);
        pchk(1'b1);
        `CHK({pin_oe_n, pin_in}, 2'b11)
        cmd(cmd_low);
        pchk(1'b0);
        `CHK({pin_oe_n, pin_in}, 2'b00)
        wr(ctrl_off, 32'h1 << unit_bit);
        rchk(div_off, 32'(div_ms_code));
        // Start with an empty list
        wr(ctrl_off, 32'(mode_toggle));
        cmd(cmd_start);
        rchk(err_off, 32'h1);
        rchk(state_off, 32'h0);
        cmd(cmd_errclr);
        rchk(err_off, 32'h0);
        // Three entries, five toggles from a low pin
        for (int i = 0; i < 3; i++) wr(list_base_off + 8'(4 * i), 32'(durs[i]));
        wr(list_len_off, 32'h3);
        wr(repc_off, 32'h5);
        cmd(cmd_start);
        rchk(remain_off, 32'h5);
        xfer(1'b0, state_off, 32'h0, v);
        `CHK(v inside {[1:3]}, 1'b1)
        wt(dt);
        `CHK(dt <= us_cycles + 8, 1'b1)
        for (int k = 1; k < 5; k++) begin
            wt(dt);
            `CHK(dt >= durs[k % 3] * us_cycles - 1 && dt <= durs[k % 3] * us_cycles + 1, 1'b1)
        end
        pchk(1'b1);
        rchk(state_off, 32'h0);
        rchk(remain_off, 32'h0);
        // Clamped entry, then one toggle from a high pin
        wr(list_base_off + 8'h08, 32'hffff);
        rchk(list_base_off + 8'h08, 32'(dur_max));
        wr(list_len_off, 32'h1);
        wr(repc_off, 32'h1);
        cmd(cmd_high);
        cmd(cmd_start);
        wt(dt);
        pchk(1'b0);
        // Count zero means 64; stop part way
        wr(repc_off, 32'h0);
        cmd(cmd_start);
        rchk(remain_off, 32'd64);
        repeat (3) wt(dt);
        rchk(remain_off, 32'd61);
        cmd(cmd_stop);
        lv = pin_out;
        repeat (300) @(negedge hclk);
        `CHK(pin_out, lv)
        rchk(state_off, 32'h0);
        cmd(cmd_high);
        cmd(cmd_start);
        cmd(cmd_reset);
        pchk(1'b0);
        rchk(state_off, 32'h0);
        // Armed start waits for the first instance
        wr(repc_off, 32'h1);
        wr(ctrl_off, 32'(mode_toggle) | (32'h1 << trig_bit));
        cmd(cmd_start);
        rchk(state_off, 32'(st_armed));
        pchk(1'b0);
        repeat (200) @(posedge hclk);
        `CHK(pin_out, 1'b0)
        trig <= 1'b1;
        wt(dt);
        `CHK(dt <= us_cycles + 8, 1'b1)
        @(posedge hclk);
        trig <= 1'b0;
        // Endless train past the repeat count
        wr(ctrl_off, 32'(mode_pwm));
        cmd(cmd_start);
        wt(dt);
        for (int k = 0; k < 3; k++) begin
            wt(da);
            wt(dt);
            `CHK(da + dt >= 3 * us_cycles - 2 && da + dt <= 3 * us_cycles + 2, 1'b1)
        end
        cmd(cmd_stop);
        // Single pulse: low for entry 0, high for entry 1, then stop low
        wr(ctrl_off, 32'(mode_pulse));
        wr(repc_off, 32'h1);
        cmd(cmd_low);
        cmd(cmd_start);
        wt(dt);
        `CHK(pin_out, 1'b1)
        wt(dt);
        `CHK(dt >= 2 * us_cycles - 1 && dt <= 2 * us_cycles + 1, 1'b1)
        pchk(1'b0);
        rchk(state_off, 32'h0);
        // One pulse on the pin under each edge selection
        src_en <= 1'b1;
        for (int m = 0; m < 3; m++) begin
            wr(ctrl_off, 32'(mode_rise) + 32'(m));
            wr(repc_off, 32'h3);
            cmd(cmd_start);
            repeat (20) @(posedge hclk);
            src_level <= 1'b1;
            repeat (20) @(posedge hclk);
            src_level <= 1'b0;
            repeat (20) @(posedge hclk);
            rchk(remain_off, (m == 2) ? 32'h1 : 32'h2);
            cmd(cmd_stop);
        end
        xfer(1'b0, capture_off, 32'h0, v);
        `CHK(v != 32'h0, 1'b1)
        report_and_stop();
    end
endmodule
`default_nettype wire
